// *** src/svr_receive_path.sv ***
// Purpose: word-rate back end of a serial digital video receiver
// Assumes: recovered serial bits arrive with a toggle strobe, bit stable >= 3 clocks
// Notes:   register port runs on the host's port clock, sampled as a pin
// Behaviour
// - NRZI to NRZ, descramble x^9+x^4+1, emit 10-bit SD or 20-bit HD words.
// - bits enter least significant first; later stages step once per word.
// - LSB de-dither runs when its enable bit is set; off after reset.
// - vertical blanking words are de-dithered only with the vertical enable set.
// - sync characters are found, words realigned to them, and retimed per word.
// - sync characters from 000h to 003h become 000h.
// - sync characters from 3FCh to 3FFh become 3FFh.
// - clipping comes after descrambling and after de-dithering.
// - with lock, format is measured, drives word width, and is readable.
// - a nonzero five-bit format field forces that single format.
// - Sd_restrict_bit and Hd_restrict_bit bits restrict detection; both clear means automatic.
// - output FIFO delay of 0 to 4 words from a 3-bit depth field.
// - EAV, SAV and NEW_SYNC_POSITION_FLAG flags come from the FIFO input stage.
// - HD luma on bits 19:10, chroma on bits 9:0.
// - SD word on bits 9:0 with an identical copy on bits 19:10.
// - output word clock runs once per received word at the word rate.
// - video data changes on the falling word clock edge, host samples rising.
// - one 10-bit port carries register traffic, steered by the two selects.
// - address and data on port bits 7:0, handshake code on bits 9:8.
// - device returns read data with 10b on the upper bits.
// - read: address on a rising edge, data driven until the next rising edge.
// - write: address on one rising edge, data stored on the following one.
`timescale 1ns/1ps
`include "svr_defs.svh"
module svr_receive_path #(
  parameter logic [3:0] VIDEO_WORD_CLOCK_HALF = `SVR_VIDEO_WORD_CLOCK_HALF
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // recovered serial stream
  input  wire logic        sdi_bit_in,
  input  wire logic        sdi_toggle_in,
  input  wire logic        cdr_lock_in,
  input  wire logic        cdr_rate_hd_in,
  // video output
  output logic      [19:0] video_out_bus_out,
  output logic             video_word_clock_out,
  // register port
  input  wire logic        port_clk_in,
  input  wire logic        port_rd_wr_in,
  input  wire logic        port_function_select_in,
  input  wire logic  [9:0] port_ad_in,
  output logic       [9:0] port_ad_out,
  output logic             port_ad_oe_out
);
  import svr_pkg::*;

  svr_state_t st_reg;
  svr_state_t st_next;

  // near-range tests tolerate dither in the two LSBs
  function automatic logic is_hi(input logic [9:0] x);
    is_hi = (x >= `SVR_TRS_HI_MIN);
  endfunction

  function automatic logic is_lo(input logic [9:0] x);
    is_lo = (x <= `SVR_TRS_LO_MAX);
  endfunction

  // de-dither first, then clip
  function automatic logic [9:0] proc10(input logic [9:0] x, input logic trs,
                                        input logic dith);
    logic [9:0] y;
    y = dith ? {x[9:1], 1'b0} : x;
    proc10 = y;
    if (trs && is_lo(y)) proc10 = `SVR_TRS_LO;
    if (trs && is_hi(y)) proc10 = `SVR_TRS_HI;
  endfunction

  logic        new_bit, nrz, dbit, match, last, emit, hd_act, forced, rise;
  logic [29:0] win_n;
  logic [19:0] word, fi, fsel;
  logic [4:0]  last_idx, fmt_code;
  logic        dith, trs_out;
  logic [2:0]  dsel;

  // read decode, refreshed every clock from the captured address
  function automatic logic [7:0] rd_mux(input svr_state_t s, input logic [4:0] fc);
    case (s.addr)
      `SVR_ADDR_VINFO0:  rd_mux = {6'h00, s.vb_undither_on, s.undither_on};
      `SVR_ADDR_FORMAT0: rd_mux = {1'b0, s.hd_restrict_bit, s.sd_restrict_bit, s.fmt_set};
      `SVR_ADDR_FORMAT1: rd_mux = {s.lock_s2, s.det_valid, 1'b0, fc};
      `SVR_ADDR_ANC0:    rd_mux = {5'h00, s.depth};
      `SVR_ADDR_TRS:     rd_mux = {4'h0, s.vblank, s.new_sync_position_flag, s.sav, s.eav};
      `SVR_ADDR_LINE_LO: rd_mux = s.line_len[7:0];
      `SVR_ADDR_LINE_HI: rd_mux = s.line_len[15:8];
      default:           rd_mux = 8'h00;
    endcase
  endfunction

  always_comb begin
    st_next = st_reg;
    // two-flop synchronisers for every pin
    st_next.sdi_s1  = sdi_bit_in;
    st_next.sdi_s2  = st_reg.sdi_s1;
    st_next.tgl_s1  = sdi_toggle_in;
    st_next.tgl_s2  = st_reg.tgl_s1;
    st_next.tgl_d   = st_reg.tgl_s2;
    st_next.lock_s1 = cdr_lock_in;
    st_next.lock_s2 = st_reg.lock_s1;
    st_next.rate_s1 = cdr_rate_hd_in;
    st_next.rate_s2 = st_reg.rate_s1;
    st_next.aclk_s1 = port_clk_in;
    st_next.aclk_s2 = st_reg.aclk_s1;
    st_next.aclk_d  = st_reg.aclk_s2;
    st_next.rw_s1   = port_rd_wr_in;
    st_next.rw_s2   = st_reg.rw_s1;
    st_next.fsel_s1 = port_function_select_in;
    st_next.fsel_s2 = st_reg.fsel_s1;
    st_next.ad_s1   = port_ad_in;
    st_next.ad_s2   = st_reg.ad_s1;

    // format selection: forced code, restriction bits, or rate from recovery
    forced   = (st_reg.fmt_set != `SVR_RST_FMT_SET);
    hd_act   = forced ? st_reg.fmt_set[4] :
               st_reg.sd_restrict_bit ? 1'b0 :
               st_reg.hd_restrict_bit ? 1'b1 : st_reg.rate_s2;
    fmt_code = forced ? st_reg.fmt_set : {hd_act, 4'h0};
    last_idx = hd_act ? `SVR_HD_LAST_BIT : `SVR_SD_LAST_BIT;

    // serial front: one new bit per strobe toggle
    new_bit = st_reg.tgl_s2 ^ st_reg.tgl_d;
    nrz     = st_reg.sdi_s2 ^ st_reg.nrzi_prev;
    dbit    = nrz ^ st_reg.scr[3] ^ st_reg.scr[8];
    win_n   = {dbit, st_reg.win[29:1]};
    // 3FF then two zero characters closes a word on either rate
    match   = is_hi(win_n[9:0]) && is_lo(win_n[19:10]) && is_lo(win_n[29:20]);
    last    = (st_reg.bitcnt == last_idx);
    emit    = new_bit && (match || last);
    word    = hd_act ? win_n[29:10] : {win_n[29:20], win_n[29:20]};

    // processing of the word leaving the alignment delay line
    trs_out = st_reg.dtrs[2];
    dith    = st_reg.undither_on &&
              (!st_reg.vblank || st_reg.vb_undither_on);
    fi      = {proc10(st_reg.dw[2][19:10], trs_out, dith),
               proc10(st_reg.dw[2][9:0], trs_out, dith)};
    dsel    = (st_reg.depth > `SVR_FIFO_MAX) ? `SVR_FIFO_MAX : st_reg.depth;
    fsel    = (dsel == 3'd0) ? fi : st_reg.fq[2'(dsel - 3'd1)];

    if (new_bit) begin
      st_next.nrzi_prev = st_reg.sdi_s2;
      st_next.scr       = {st_reg.scr[7:0], nrz};
      st_next.win       = win_n;
      st_next.bitcnt    = emit ? 5'd0 : 5'(st_reg.bitcnt + 5'd1);
    end

    if (emit) begin
      // alignment delay line: a match tags the two preceding words too
      st_next.dw      = {st_reg.dw[1], st_reg.dw[0], word};
      st_next.dtrs    = {st_reg.dtrs[1] | match, st_reg.dtrs[0] | match, match};
      st_next.dxyz    = {st_reg.dxyz[1:0], st_reg.xyz_pend & !match};
      st_next.dnsp    = {st_reg.dnsp[1:0], match & !last};
      st_next.xyz_pend = match;
      // fifo input stage drives the look-ahead flags
      if (st_reg.dxyz[2]) begin
        st_next.eav    = st_reg.dw[2][6];
        st_next.sav    = !st_reg.dw[2][6];
        st_next.vblank = st_reg.dw[2][7];
      end
      // line length measured between end-of-active markers
      if (st_reg.dxyz[2] && st_reg.dw[2][6]) begin
        st_next.line_len  = st_reg.line_cnt;
        st_next.line_cnt  = 16'h0001;   // the EAV word opens the next line
        st_next.det_valid = st_reg.lock_s2;
      end else begin
        st_next.line_cnt  = 16'(st_reg.line_cnt + 16'h0001);
      end
      st_next.fq   = {st_reg.fq[2:0], fi};
      // word clock falls as the new word appears
      st_next.vout = fsel;
      st_next.video_word_clock = 1'b0;
      st_next.vcnt = VIDEO_WORD_CLOCK_HALF;
    end else if (st_reg.vcnt != 4'h0) begin
      st_next.vcnt = 4'(st_reg.vcnt - 4'h1);
      if (st_reg.vcnt == 4'h1) st_next.video_word_clock = 1'b1;
    end
    if (!st_reg.lock_s2) st_next.det_valid = 1'b0;

    // register port, stepped on synchronised rising port clock edges
    rise = st_reg.aclk_s2 && !st_reg.aclk_d;
    if (rise) begin
      if (st_reg.init_cnt != `SVR_INIT_EDGES) begin
        st_next.init_cnt = 2'(st_reg.init_cnt + 2'd1);
      end else if (st_reg.fsel_s2) begin
        // ancillary traffic has no source here; port stays released
        st_next.pst   = SVR_P_IDLE;
        st_next.ad_oe = 1'b0;
      end else begin
        case (st_reg.pst)
          SVR_P_IDLE: begin
            if (st_reg.ad_s2[9:8] == `SVR_TAG_ADDR) begin
              st_next.addr = st_reg.ad_s2[7:0];
              if (st_reg.rw_s2) begin
                st_next.pst   = SVR_P_RDRIVE;
                st_next.ad_oe = 1'b1;
              end else begin
                st_next.pst = SVR_P_WDATA;
              end
            end
          end
          SVR_P_WDATA: begin
            st_next.pst = SVR_P_IDLE;
            if (st_reg.ad_s2[9:8] == `SVR_TAG_WDATA) begin
              case (st_reg.addr)
                `SVR_ADDR_VINFO0: begin
                  st_next.undither_on    = st_reg.ad_s2[`SVR_VINFO_UNDITH];
                  st_next.vb_undither_on = st_reg.ad_s2[`SVR_VINFO_VBUND];
                end
                `SVR_ADDR_FORMAT0: begin
                  st_next.fmt_set = st_reg.ad_s2[4:0];
                  st_next.sd_restrict_bit = st_reg.ad_s2[`SVR_FMT_SD_BIT];
                  st_next.hd_restrict_bit = st_reg.ad_s2[`SVR_FMT_HD_BIT];
                end
                `SVR_ADDR_ANC0: st_next.depth = st_reg.ad_s2[2:0];
                `SVR_ADDR_TRS: begin
                  if (st_reg.ad_s2[`SVR_TRS_NSP_BIT]) st_next.new_sync_position_flag = 1'b0;
                end
                default: ;
              endcase
            end
          end
          SVR_P_RDRIVE: begin
            st_next.pst   = SVR_P_IDLE;
            st_next.ad_oe = 1'b0;
          end
          default: begin
            st_next.pst   = SVR_P_IDLE;
            st_next.ad_oe = 1'b0;
          end
        endcase
      end
    end
    // read data follows the captured address
    st_next.rdata = rd_mux(st_reg, fmt_code);
    // new sync position is sticky; a fresh event beats a clear
    if (emit && st_reg.dnsp[2]) st_next.new_sync_position_flag = 1'b1;
  end

  // single state register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_reg          <= '0;
      st_reg.video_word_clock     <= 1'b1;
      st_reg.fmt_set  <= `SVR_RST_FMT_SET;
      st_reg.depth    <= `SVR_RST_DEPTH;
      st_reg.pst      <= SVR_P_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from state flops
  assign video_out_bus_out    = st_reg.vout;
  assign video_word_clock_out = st_reg.video_word_clock;
  assign port_ad_out          = {`SVR_TAG_RDATA, st_reg.rdata};
  assign port_ad_oe_out       = st_reg.ad_oe;
endmodule // svr_receive_path

// *** src/svr_defs.svh ***
// Purpose: constants for the serial video receive back end
// Assumes: included by the design file by its bare name
// Notes:   register offsets sit on the 8-bit port address space
`ifndef SVR_DEFS_SVH
`define SVR_DEFS_SVH
// register offsets
`define SVR_ADDR_VINFO0   8'h00
`define SVR_ADDR_FORMAT0  8'h01
`define SVR_ADDR_FORMAT1  8'h02
`define SVR_ADDR_ANC0     8'h03
`define SVR_ADDR_TRS      8'h04
`define SVR_ADDR_LINE_LO  8'h05
`define SVR_ADDR_LINE_HI  8'h06
// field positions
`define SVR_VINFO_UNDITH  0
`define SVR_VINFO_VBUND   1
`define SVR_FMT_SD_BIT    5
`define SVR_FMT_HD_BIT    6
`define SVR_TRS_NSP_BIT   2
// reset values
`define SVR_RST_FMT_SET   5'h00
`define SVR_RST_DEPTH     3'h0
// handshake codes on the upper port bits
`define SVR_TAG_ADDR      2'b00
`define SVR_TAG_WDATA     2'b11
`define SVR_TAG_RDATA     2'b10
// timing reference values and clipping bounds
`define SVR_TRS_HI        10'h03ff
`define SVR_TRS_LO        10'h0000
`define SVR_TRS_HI_MIN    10'h03fc
`define SVR_TRS_LO_MAX    10'h0003
// counts
`define SVR_INIT_EDGES    2'd3
`define SVR_FIFO_MAX      3'd4
`define SVR_SD_LAST_BIT   5'd9
`define SVR_HD_LAST_BIT   5'd19
`define SVR_VIDEO_WORD_CLOCK_HALF     4'd2
`endif

// *** src/svr_pkg.sv ***
// Purpose: types shared by the serial video receive back end
// Assumes: svr_defs.svh holds the numeric constants
// Notes:   each port state sits one bit away from idle, its only neighbour
package svr_pkg;
  typedef enum logic [1:0] {
    SVR_P_IDLE   = 2'b00,
    SVR_P_WDATA  = 2'b01,
    SVR_P_RDRIVE = 2'b10
  } svr_port_st_t;

  typedef struct packed {
    logic             sdi_s1, sdi_s2, tgl_s1, tgl_s2, tgl_d;
    logic             lock_s1, lock_s2, rate_s1, rate_s2;
    logic             aclk_s1, aclk_s2, aclk_d;
    logic             rw_s1, rw_s2, fsel_s1, fsel_s2;
    logic [9:0]       ad_s1, ad_s2;
    logic             nrzi_prev;
    logic [8:0]       scr;
    logic [29:0]      win;
    logic [4:0]       bitcnt;
    logic             xyz_pend;
    logic [2:0][19:0] dw;
    logic [2:0]       dtrs, dxyz, dnsp;
    logic             vblank, eav, sav, new_sync_position_flag;
    logic [3:0][19:0] fq;
    logic [19:0]      vout;
    logic             video_word_clock;
    logic [3:0]       vcnt;
    logic [15:0]      line_cnt, line_len;
    logic             det_valid;
    logic             undither_on, vb_undither_on, sd_restrict_bit, hd_restrict_bit;
    logic [4:0]       fmt_set;
    logic [2:0]       depth;
    svr_port_st_t     pst;
    logic [7:0]       addr, rdata;
    logic             ad_oe;
    logic [1:0]       init_cnt;
  } svr_state_t;
endpackage

// *** dv/svr_host_model.sv ***
// Purpose: host controller model on the register port
// Assumes: port clock halves of six system clocks
// Notes:   a released port shows a pattern that flips every clock
`timescale 1ns/1ps
module svr_host_model (
  // clock
  input  wire logic       clk_in,
  // port as the host sees it
  input  wire logic [9:0] port_ad_in,
  input  wire logic       port_ad_oe_in,
  // host drive
  output logic            port_clk_out,
  output logic            port_rd_wr_out,
  output logic            port_function_select_out,
  output logic      [9:0] port_ad_out
);
  logic       drive_reg = 1'b0;
  logic [9:0] val_reg   = 10'h000;
  logic [9:0] flt_reg   = 10'h155;

  // idle levels at time zero
  initial begin
    port_clk_out             = 1'b0;
    port_rd_wr_out           = 1'b0;
    port_function_select_out = 1'b0;
  end

  // released lines never keep the last value, so a stale read shows
  always @(posedge clk_in) flt_reg <= ~flt_reg;
  assign port_ad_out = drive_reg ? val_reg : flt_reg;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // one port clock period; six clocks covers the pin synchroniser
  task automatic pulse();
    cyc(6);
    port_clk_out <= 1'b1;
    cyc(6);
    port_clk_out <= 1'b0;
  endtask

  task automatic init();
    cyc(1);
    repeat (3) pulse();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    port_function_select_out <= 1'b0;
    port_rd_wr_out           <= 1'b0;
    drive_reg                <= 1'b1;
    val_reg                  <= {2'b00, a};
    pulse();
    val_reg <= {2'b11, d};
    pulse(); // data taken on the second rise
    drive_reg <= 1'b0;
  endtask

  task automatic rd(input logic sel, input logic [7:0] a, output logic [11:0] got);
    cyc(1);
    port_function_select_out <= sel;
    port_rd_wr_out           <= 1'b1;
    drive_reg                <= 1'b1;
    val_reg                  <= {2'b00, a};
    pulse();
    drive_reg <= 1'b0;
    cyc(8);
    #1;
    got[11]  = port_ad_oe_in;
    got[9:0] = port_ad_in;
    pulse(); // second rise frees the port
    #1;
    got[10] = port_ad_oe_in;
  endtask
endmodule // svr_host_model

// *** dv/svr_receive_path_props.sv ***
// Purpose: port-level assertions for the receive back end
// Assumes: one clock domain, host holds selects for a whole access
// Notes:   pin events are seen some clocks before the synchroniser acts
`timescale 1ns/1ps
module svr_receive_path_chk #(
  parameter logic [3:0] VIDEO_WORD_CLOCK_HALF = 4'h2
) (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  // watched pins
  input wire logic        cdr_rate_hd_in,
  input wire logic [19:0] video_out_bus_out,
  input wire logic        video_word_clock_out,
  input wire logic        port_clk_in,
  input wire logic        port_rd_wr_in,
  input wire logic        port_function_select_in,
  input wire logic [9:0]  port_ad_in,
  input wire logic [9:0]  port_ad_out,
  input wire logic        port_ad_oe_out
);
  localparam int HALF = VIDEO_WORD_CLOCK_HALF;
  logic [1:0] rise_cnt_reg;

  // first three port clock rises only initialise the port
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rise_cnt_reg <= 2'h0;
    end else if ($rose(port_clk_in) && rise_cnt_reg != 2'h3) begin
      rise_cnt_reg <= rise_cnt_reg + 2'h1;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  chk_read_tag: assert property (port_ad_oe_out |-> port_ad_out[9:8] == 2'b10)
    else $error("read data carries a wrong upper code");
  chk_read_answer: assert property (rise_cnt_reg == 2'h3 && $rose(port_clk_in)
    && port_rd_wr_in && !port_function_select_in && port_ad_in[9:8] == 2'b00
    && !port_ad_oe_out |-> ##[1:6] port_ad_oe_out)
    else $error("read address not answered");
  chk_oe_release: assert property (port_ad_oe_out && $rose(port_clk_in)
    |-> ##[1:6] !port_ad_oe_out)
    else $error("port not released after the second rise");
  chk_oe_stands: assert property ($fell(port_ad_oe_out) |-> $past(port_clk_in, 2))
    else $error("port released without a port clock rise");
  chk_data_on_fall: assert property ($changed(video_out_bus_out)
    |-> $fell(video_word_clock_out))
    else $error("video data moved off the falling word clock");
  chk_video_word_clock_low: assert property ($fell(video_word_clock_out)
    |-> ##HALF $rose(video_word_clock_out))
    else $error("word clock low phase has wrong length");
  chk_sd_halves: assert property (!cdr_rate_hd_in
    |-> video_out_bus_out[19:10] == video_out_bus_out[9:0])
    else $error("sd halves differ");
  chk_anc_quiet: assert property (port_function_select_in
    && $past(port_function_select_in, 8) |-> !port_ad_oe_out)
    else $error("control data driven in ancillary mode");

  cov_read: cover property ($rose(port_ad_oe_out));
  cov_word: cover property ($fell(video_word_clock_out) && video_out_bus_out != 20'h0_0000);
  cov_clip: cover property (video_out_bus_out == 20'hf_ffff);
endmodule // svr_receive_path_chk

bind svr_receive_path svr_receive_path_chk #(.VIDEO_WORD_CLOCK_HALF(VIDEO_WORD_CLOCK_HALF)) u_chk (
  .clk_in, .reset_n_in, .cdr_rate_hd_in, .video_out_bus_out, .video_word_clock_out,
  .port_clk_in, .port_rd_wr_in, .port_function_select_in, .port_ad_in, .port_ad_out,
  .port_ad_oe_out);

// *** dv/svr_receive_path_bench.sv ***
// Purpose: self-checking bench for the receive back end
// Assumes: host model drives the port, serial bits are made here
// Notes:   register rows first, then two sd streams checked for clipping
`timescale 1ns/1ps
module svr_receive_path_bench;
  import svr_pkg::*;
  typedef struct { logic [7:0] a, d, e; } svr_row_t;
  logic        clk_in         = 1'b0;
  logic        reset_n_in     = 1'b0;
  logic        sdi_bit_in     = 1'b0;
  logic        sdi_toggle_in  = 1'b0;
  logic        cdr_lock_in    = 1'b0;
  logic        cdr_rate_hd_in = 1'b0;
  logic [19:0] vid;
  logic        video_word_clock, pclk, rw, fsel, dev_oe, grab;
  logic [9:0]  dev_ad, host_ad, ad_bus;
  logic [8:0]  scr_q = 9'h000;
  logic        nrzi  = 1'b0;
  logic [11:0] got;
  logic [19:0] words [$];
  int          failures = 0;
  int          comparisons = 0;
  // write, then read back: address, data, expected read
  svr_row_t rows [6] = '{'{8'h00, 8'h03, 8'h03}, '{8'h01, 8'h25, 8'h25},
    '{8'h01, 8'h00, 8'h00}, '{8'h03, 8'h04, 8'h04}, '{8'h7f, 8'h55, 8'h00},
    '{8'h00, 8'h00, 8'h00}};

  svr_receive_path uut (.clk_in, .reset_n_in, .sdi_bit_in, .sdi_toggle_in, .cdr_lock_in,
    .cdr_rate_hd_in, .video_out_bus_out(vid), .video_word_clock_out(video_word_clock),
    .port_clk_in(pclk), .port_rd_wr_in(rw), .port_function_select_in(fsel),
    .port_ad_in(ad_bus), .port_ad_out(dev_ad), .port_ad_oe_out(dev_oe));
  svr_host_model host (.clk_in, .port_ad_in(ad_bus), .port_ad_oe_in(dev_oe),
    .port_clk_out(pclk), .port_rd_wr_out(rw), .port_function_select_out(fsel),
    .port_ad_out(host_ad));

  // device wins the shared port while it drives
  assign ad_bus = dev_oe ? dev_ad : host_ad;

  initial begin
    forever #10 clk_in = ~clk_in;
  end

  // words taken at the rising word clock, between the falling edges
  always @(posedge video_word_clock) if (grab) words.push_back(vid);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // scramble, then nrzi; toggle kept clear of the bit change
  task automatic send_bit(input logic d);
    logic s;
    s = d ^ scr_q[3] ^ scr_q[8];
    scr_q = {scr_q[7:0], s};
    nrzi = nrzi ^ s;
    sdi_bit_in <= nrzi;
    repeat (2) @(posedge clk_in);
    sdi_toggle_in <= ~sdi_toggle_in;
    repeat (2) @(posedge clk_in);
  endtask

  task automatic send_word(input logic [9:0] w);
    for (int i = 0; i < 10; i++) send_bit(w[i]);
  endtask

  // three lines of sync, xyz and fill; then look at the last sync out
  task automatic stream(input logic [9:0] fill, input logic [9:0] xyz);
    logic [9:0] ln [10];
    logic [9:0] ex [6];
    int         k;
    ln = '{10'h3fd, 10'h002, 10'h001, xyz, 10'h201, 10'h201, 10'h201, 10'h201,
      10'h201, 10'h201};
    ex = '{10'h3ff, 10'h000, 10'h000, xyz, fill, fill};
    k = -1;
    words.delete();
    grab = 1'b1;
    repeat (3) foreach (ln[i]) send_word(ln[i]);
    repeat (12) send_word(10'h201);
    grab = 1'b0;
    foreach (words[i]) if (words[i] === {2{10'h3ff}}) k = i;
    check(k > 0, 1);
    for (int i = 0; i < 6; i++) check(words[k + i], {2{ex[i]}});
  endtask

  initial begin
    grab = 1'b0;
    #500000;
    failures++;
    summarize();
  end

  initial begin
    repeat (10) @(posedge clk_in);
    check({vid, video_word_clock, dev_oe, dev_ad}, {20'h0_0000, 1'b1, 1'b0, 10'h200});
    reset_n_in <= 1'b1;
    cdr_lock_in <= 1'b1;
    host.init();
    for (int a = 0; a < 4; a++) begin
      if (a != 2) begin
        host.rd(1'b0, 8'(a), got);
        check(got, 12'ha00);
      end
    end
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].d);
      host.rd(1'b0, rows[i].a, got);
      check(got, {4'ha, rows[i].e});
    end
    host.rd(1'b1, 8'h00, got);
    check(got[11], 1'b0);
    stream(10'h201, 10'h240);
    host.rd(1'b0, 8'h02, got);
    check(got, 12'hac0);
    host.rd(1'b0, 8'h04, got);
    check(got, 12'ha01);
    host.rd(1'b0, 8'h05, got);
    check(got, 12'ha0a);
    host.rd(1'b0, 8'h06, got);
    check(got, 12'ha00);
    // five stray bits move the word boundary, so the next sync is a new position
    repeat (5) send_bit(1'b0);
    host.wr(8'h00, 8'h03);
    host.wr(8'h01, 8'h20);
    cdr_rate_hd_in <= 1'b1;
    stream(10'h200, 10'h2c0);
    host.rd(1'b0, 8'h04, got);
    check(got, 12'ha0d);
    host.wr(8'h04, 8'h04);
    host.rd(1'b0, 8'h04, got);
    check(got, 12'ha09);
    host.rd(1'b0, 8'h02, got);
    check(got, 12'hac0);
    host.wr(8'h01, 8'h00);
    host.rd(1'b0, 8'h02, got);
    check(got, 12'had0);
    // reset in mid-run: outputs and registers fall back to their idle values
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check({vid, video_word_clock, dev_oe, dev_ad}, {20'h0_0000, 1'b1, 1'b0, 10'h200});
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    @(negedge clk_in);
    check({vid, video_word_clock, dev_oe, dev_ad}, {20'h0_0000, 1'b1, 1'b0, 10'h200});
    host.init();
    for (int a = 0; a < 4; a++) begin
      if (a != 2) begin
        host.rd(1'b0, 8'(a), got);
        check(got, 12'ha00);
      end
    end
    summarize();
  end
endmodule // svr_receive_path_bench
